// file: hw/dmsea_host.sv
/*
  master end: turns one command at a time into start, bytes, ack bits
  and stop on the two-wire link, and drives the two level pins.
  assumes the user holds the command fields while cmd_valid is high.
*/
`timescale 1ns/1ps
module dmsea_host #(
  parameter int QTR_CYCLES = dmsea_pkg::SCL_QTR_CYCLES
) (
  // system clock and reset
  input wire logic clk,
  input wire logic reset,
  // bus pins
  dmsea_bus_if.host_mp bus,
  // command
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire dmsea_pkg::dmsea_op_e cmd_op,
  input wire logic [6:0] cmd_addr,
  input wire logic [7:0] cmd_wdata,
  input wire logic [7:0] cmd_count,
  // pin levels
  input wire logic txo_run,
  input wire logic write_enable_level,
  input wire logic protect_level,
  // answers
  output logic rx_valid,
  output logic [7:0] rx_data,
  output logic done,
  output logic done_ack
);
  import dmsea_pkg::*;

  // whole master state
  typedef struct packed {
    dmsea_hst_e st; // bus state
    dmsea_phase_e ph; // byte phase
    dmsea_op_e op; // latched command
    logic [6:0] addr; // latched address
    logic [7:0] wdata; // latched data
    logic [7:0] count; // bytes left after the current one
    logic [TICK_W-1:0] tick; // quarter divider
    logic [1:0] qtr; // quarter within a bit
    logic [3:0] idx; // bit index, 8 is the ack bit
    logic rxm; // receiving byte
    logic [7:0] sh; // shift register
    logic ackok; // last ack seen
    logic [1:0] sda_s; // data synchroniser
    logic toc; // transmit clock pin
    logic wp; // protect pin
    logic scl_oe; // pull clock low
    logic sda_oe; // pull data low
    logic rxv; // byte received pulse
    logic [7:0] rxd; // received byte
    logic dn; // command done pulse
    logic dack; // command acked throughout
  } dmsea_host_s;

  dmsea_host_s q;
  dmsea_host_s d;
  logic tk; // quarter boundary
  logic bv; // bit value on the wire

  // next state
  always_comb begin
    d = q;
    d.rxv = 1'b0;
    d.dn = 1'b0;
    d.sda_s = {q.sda_s[0], bus.sda};
    tk = (q.tick == TICK_W'(QTR_CYCLES - 1));
    d.tick = tk ? '0 : q.tick + TICK_W'(1);
    d.wp = protect_level;
    // free toggling makes the transmit-only clock, else a write level
    if (tk) begin
      d.toc = txo_run ? ~q.toc : write_enable_level;
    end
    case (q.st)
      H_IDLE: begin
        // a poll may follow the stop of a write with no gap
        if (cmd_valid) begin // [RULE_03]
          d.op = cmd_op;
          d.addr = cmd_addr;
          d.wdata = cmd_wdata;
          d.count = cmd_count;
          d.ph = P_CTRL;
          d.dack = 1'b1;
          d.st = H_START;
          d.qtr = 2'h0;
          d.tick = '0;
        end
      end
      H_START: begin
        if (tk) begin
          d.qtr = q.qtr + 2'h1;
          if (q.qtr == 2'h3) begin
            // reads differ from writes only in the direction bit
            d.sh = {SLAVE_ADDR, (q.ph == P_CTRLR) || (q.op == OP_READ_CUR)}; // [RULE_08]
            d.st = H_BIT;
            d.idx = 4'h0;
            d.rxm = 1'b0;
          end
        end
      end
      H_BIT: begin
        if (tk) begin
          d.qtr = q.qtr + 2'h1;
          if (q.qtr == 2'h2) begin
            if (q.rxm && q.idx < 4'h8) begin
              d.sh = {q.sh[6:0], q.sda_s[1]};
            end else if (!q.rxm && q.idx == 4'h8) begin
              d.ackok = ~q.sda_s[1]; // [RULE_02]
            end
          end else if (q.qtr == 2'h3) begin
            if (q.idx < 4'h8) begin
              d.idx = q.idx + 4'h1;
              if (!q.rxm) begin
                d.sh = {q.sh[6:0], 1'b0};
              end
            end else if (!q.rxm) begin
              d.idx = 4'h0;
              if (!q.ackok) begin
                d.dack = 1'b0;
                d.st = H_STOP;
              end else begin
                case (q.ph)
                  P_CTRL: begin
                    if (q.op == OP_POLL) begin
                      d.st = H_STOP; // [RULE_02]
                    end else if (q.op == OP_READ_CUR) begin
                      d.rxm = 1'b1; // [RULE_09]
                      d.ph = P_RX;
                    end else begin
                      d.sh = {1'b0, q.addr};
                      d.ph = P_ADDR;
                    end
                  end
                  P_ADDR: begin
                    if (q.op == OP_READ_RAND) begin
                      d.ph = P_CTRLR; // [RULE_11]
                      d.st = H_START;
                    end else begin
                      d.sh = q.wdata;
                      d.ph = P_DATA;
                    end
                  end
                  P_CTRLR: begin
                    d.rxm = 1'b1; // [RULE_12]
                    d.ph = P_RX;
                  end
                  P_DATA: begin
                    // page write: count more bytes, each one up from the last
                    d.st = (q.count == 8'h0) ? H_STOP : H_BIT;
                    d.count = q.count - 8'h1;
                    d.wdata = q.wdata + 8'h1;
                    d.sh = q.wdata + 8'h1;
                  end
                  default: begin
                    d.st = H_STOP;
                  end
                endcase
              end
            end else begin
              // byte in: deliver it, then stop or ask for more
              d.rxv = 1'b1;
              d.rxd = q.sh;
              d.idx = 4'h0;
              if (q.count == 8'h0) begin
                d.st = H_STOP; // [RULE_10]
              end else begin
                d.count = q.count - 8'h1; // [RULE_13]
              end
            end
          end
        end
      end
      H_STOP: begin
        if (tk) begin
          d.qtr = q.qtr + 2'h1;
          if (q.qtr == 2'h3) begin
            d.st = H_IDLE;
            d.dn = 1'b1;
          end
        end
      end
      default: begin
        d.st = H_IDLE;
      end
    endcase
    // pin drive follows the next state, so the pins come from flops
    bv = d.rxm ? ((d.idx < 4'h8) | (d.count == 8'h0)) : ((d.idx < 4'h8) ? d.sh[7] : 1'b1);
    case (d.st)
      H_START: begin
        d.sda_oe = d.qtr[1];
        d.scl_oe = (d.qtr == 2'h0) || (d.qtr == 2'h3);
      end
      H_BIT: begin
        // data only changes while the clock is low
        d.sda_oe = ~bv; // [RULE_15]
        d.scl_oe = (d.qtr == 2'h0) || (d.qtr == 2'h3);
      end
      H_STOP: begin
        d.sda_oe = ~d.qtr[1];
        d.scl_oe = (d.qtr == 2'h0);
      end
      default: begin
        d.sda_oe = 1'b0;
        d.scl_oe = 1'b0; // [RULE_16]
      end
    endcase
  end

  // state register
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      q <= '0;
      q.st <= H_IDLE;
      q.ph <= P_CTRL;
      q.op <= OP_WRITE;
      q.sda_s <= 2'h3;
      q.wp <= 1'b1;
    end else begin
      q <= d;
    end
  end

  // outputs
  assign cmd_ready = (q.st == H_IDLE);
  assign bus.host_scl_o = 1'b0;
  assign bus.host_scl_oe = q.scl_oe;
  assign bus.host_sda_o = 1'b0;
  assign bus.host_sda_oe = q.sda_oe;
  assign bus.transmit_only_clock = q.toc;
  assign bus.write_protect_pin = q.wp;
  assign rx_valid = q.rxv;
  assign rx_data = q.rxd;
  assign done = q.dn;
  assign done_ack = q.dack;
endmodule // dmsea_host

// file: hw/dmsea_pkg.sv
/*
  shared constants and types for the dual-mode serial eeprom access pair:
  slave address, array geometry, timing counts and state encodings.
  assumes both ends import it; the device end runs on the link clock.
*/
// Functional notes
// RULE_01: no control byte ack while write busy
// RULE_02: poll with write control byte; ack when done
// RULE_03: master may poll right after write stop
// RULE_04: writes need transmit-only clock held high
// RULE_05: write to last location sets fuse permanently
// RULE_06: fuse clear: protect pin ignored, writable
// RULE_07: fuse set: protect pin low means read-only
// RULE_08: reads start like writes, direction bit one
// RULE_09: current read sends byte after last access
// RULE_10: master nacks last byte; device releases data
// RULE_11: repeated start loads pointer, aborts write
// RULE_12: read control byte acked, loaded byte sent
// RULE_13: master ack requests next sequential byte
// RULE_14: pointer advances after every byte operation
// RULE_15: data change while clock high: start/stop
// RULE_16: clock line transition leaves transmit-only mode
// RULE_17: transmit-only: bit out per clock rise
// RULE_18: respond only to address 1010000
// RULE_19: bidirectional mode kept until power removed
// RULE_20: page write increments low three bits only
// RULE_21: clock level ignored during program cycle
// RULE_22: read pointer wraps last to first
// RULE_23: protected write changes neither array nor fuse
package dmsea_pkg;
  // bus addressing
  localparam logic [6:0] SLAVE_ADDR = 7'h50;
  // array geometry
  localparam int ADDR_W = 7;
  localparam int MEM_DEPTH = 128;
  localparam int PAGE_SIZE = 8;
  localparam logic [3:0] LAST_PAGE = 4'hf;
  localparam int LAST_IN_PAGE = 7;
  localparam logic [7:0] MEM_RESET = 8'hff;
  // self-timed write cycle, counted on the link clock
  localparam int LINK_PERIOD_NS = 64;
  localparam int WRITE_TIME_NS = 1000000;
  localparam int WRITE_CYCLES = (WRITE_TIME_NS + LINK_PERIOD_NS - 1) / LINK_PERIOD_NS;
  localparam int BUSY_W = 24;
  // master side bus timing on the system clock
  localparam int CLK_PERIOD_NS = 100;
  localparam int SCL_PERIOD_NS = 10000;
  localparam int SCL_QTR_CYCLES = SCL_PERIOD_NS / (4 * CLK_PERIOD_NS);
  localparam int TICK_W = 16;
  // device bus states
  typedef enum logic [2:0] {
    D_IDLE = 3'h0, D_RX = 3'h1, D_ACK = 3'h2, D_TX = 3'h3, D_TACK = 3'h4
  } dmsea_dst_e;
  // which byte the device is receiving
  typedef enum logic [1:0] {K_CTRL = 2'h0, K_ADDR = 2'h1, K_DATA = 2'h2} dmsea_kind_e;
  // master commands
  typedef enum logic [1:0] {
    OP_WRITE = 2'h0, OP_READ_CUR = 2'h1, OP_READ_RAND = 2'h2, OP_POLL = 2'h3
  } dmsea_op_e;
  // master bus states
  typedef enum logic [1:0] {H_IDLE = 2'h0, H_START = 2'h1, H_BIT = 2'h2, H_STOP = 2'h3} dmsea_hst_e;
  // master byte phases within a command
  typedef enum logic [2:0] {
    P_CTRL = 3'h0, P_ADDR = 3'h1, P_DATA = 3'h2, P_CTRLR = 3'h3, P_RX = 3'h4
  } dmsea_phase_e;
endpackage

// file: hw/dmsea_bus_if.sv
/*
  two-wire link between master and eeprom, plus the two level pins.
  assumes pull-ups: a line is low only while some end enables its driver.
*/
`timescale 1ns/1ps
interface dmsea_bus_if;
  logic host_scl_o; // master clock driver value
  logic host_scl_oe; // master pulls clock low
  logic host_sda_o; // master data driver value
  logic host_sda_oe; // master pulls data low
  logic dev_sda_o; // device data driver value
  logic dev_sda_oe; // device pulls data low
  logic transmit_only_clock; // transmit clock and write enable level
  logic write_protect_pin; // protect pin, active low
  logic scl; // resolved clock line
  logic sda; // resolved data line
  // open-drain resolution with pull-up
  assign scl = ~(host_scl_oe & ~host_scl_o);
  assign sda = ~((host_sda_oe & ~host_sda_o) | (dev_sda_oe & ~dev_sda_o));
  modport dev_mp (
    input scl, sda, transmit_only_clock, write_protect_pin,
    output dev_sda_o, dev_sda_oe
  );
  modport host_mp (
    input sda,
    output host_scl_o, host_scl_oe, host_sda_o, host_sda_oe,
    output transmit_only_clock, write_protect_pin
  );
endinterface // dmsea_bus_if

// file: hw/dmsea_device.sv
/*
  eeprom end: 128 x 8 array, transmit-only streaming, two-wire slave,
  page buffer, self-timed write cycle and write protection fuse.
  assumes link_clk is a free running sampling clock several times faster
  than the bus; every pin passes two flip-flops before use.
*/
`timescale 1ns/1ps
module dmsea_device #(
  parameter int WRITE_CYCLES = dmsea_pkg::WRITE_CYCLES
) (
  // link clock and power-up reset
  input wire logic link_clk,
  input wire logic reset,
  // bus pins
  dmsea_bus_if.dev_mp bus,
  // status
  output logic bidi_mode,
  output logic write_busy,
  output logic fuse_set
);
  import dmsea_pkg::*;

  // whole device state
  typedef struct packed {
    logic [MEM_DEPTH-1:0][7:0] mem; // array contents
    logic [PAGE_SIZE-1:0][7:0] pbuf; // page buffer data
    logic [PAGE_SIZE-1:0] pmask; // page buffer entries filled
    logic [3:0] page; // page the buffer belongs to
    logic [2:0] scl_s; // clock synchroniser and history
    logic [2:0] sda_s; // data synchroniser and history
    logic [2:0] toc_s; // transmit clock synchroniser and history
    logic [1:0] wp_s; // protect pin synchroniser
    logic bidi; // bidirectional mode entered
    dmsea_dst_e st; // bus state
    dmsea_dst_e nxt; // state after the ack bit
    dmsea_kind_e kind; // byte being received
    logic [3:0] bitcnt; // bit counter
    logic [7:0] sh; // shift register
    logic [ADDR_W-1:0] ptr; // address pointer
    logic wr_ok; // write enable held through the transfer
    logic fuse; // protection fuse
    logic [BUSY_W-1:0] busy_cnt; // remaining program cycle
    logic sda_oe; // pull data low
  } dmsea_dev_s;

  dmsea_dev_s q;
  dmsea_dev_s d;
  logic scl_n; // synchronised clock now
  logic scl_p; // synchronised clock one cycle ago
  logic sda_n; // synchronised data now
  logic sda_p; // synchronised data one cycle ago
  logic rise; // clock rising edge
  logic fall; // clock falling edge
  logic start_c; // start condition
  logic stop_c; // stop condition
  logic toc_rise; // transmit clock rising edge
  logic wen; // write enable from pins and fuse
  logic busy; // program cycle running

  // next state
  always_comb begin
    d = q;
    d.scl_s = {q.scl_s[1:0], bus.scl};
    d.sda_s = {q.sda_s[1:0], bus.sda};
    d.toc_s = {q.toc_s[1:0], bus.transmit_only_clock};
    d.wp_s = {q.wp_s[0], bus.write_protect_pin};
    scl_n = q.scl_s[1];
    scl_p = q.scl_s[2];
    sda_n = q.sda_s[1];
    sda_p = q.sda_s[2];
    rise = scl_n & ~scl_p;
    fall = ~scl_n & scl_p;
    // data moving while the clock stays high marks start or stop
    start_c = scl_n & scl_p & sda_p & ~sda_n; // [RULE_15]
    stop_c = scl_n & scl_p & ~sda_p & sda_n; // [RULE_15]
    toc_rise = q.toc_s[1] & ~q.toc_s[2];
    // pin is only honoured once the fuse is blown
    wen = q.toc_s[1] & (~q.fuse | q.wp_s[1]); // [RULE_04] [RULE_06] [RULE_07]
    busy = (q.busy_cnt != '0);
    // the program cycle runs out regardless of the pins
    if (busy) begin
      d.busy_cnt = q.busy_cnt - BUSY_W'(1); // [RULE_21]
    end
    if (!q.bidi) begin
      // transmit-only: stream the array, msb first
      if (fall) begin
        d.bidi = 1'b1; // [RULE_16]
        d.sda_oe = 1'b0;
        d.st = D_IDLE;
        d.bitcnt = 4'h0;
      end else if (toc_rise) begin
        d.sda_oe = ~q.mem[q.ptr][3'h7 - q.bitcnt[2:0]]; // [RULE_17]
        d.bitcnt = {1'b0, q.bitcnt[2:0] + 3'h1};
        if (q.bitcnt[2:0] == 3'h7) begin
          d.ptr = q.ptr + ADDR_W'(1); // [RULE_22]
        end
      end
    end else begin
      // a low enable level anywhere in the transfer spoils the write
      if (q.st != D_IDLE && !wen) begin
        d.wr_ok = 1'b0; // [RULE_04]
      end
      if (start_c) begin
        // a repeated start drops buffered data but keeps the pointer
        d.st = D_RX; // [RULE_11]
        d.kind = K_CTRL;
        d.bitcnt = 4'h0;
        d.sda_oe = 1'b0;
        d.pmask = '0; // [RULE_11]
        d.wr_ok = 1'b1;
      end else if (stop_c) begin
        d.st = D_IDLE;
        d.sda_oe = 1'b0;
        // commit only a fully enabled transfer
        if (q.pmask != '0 && q.wr_ok && wen) begin // [RULE_23]
          for (int i = 0; i < PAGE_SIZE; i++) begin
            if (q.pmask[i]) begin
              d.mem[{q.page, 3'(i)}] = q.pbuf[i];
            end
          end
          // fuse blows on a good write to the last location
          if (q.pmask[LAST_IN_PAGE] && q.page == LAST_PAGE) begin
            d.fuse = 1'b1; // [RULE_05]
          end
          d.busy_cnt = BUSY_W'(WRITE_CYCLES); // [RULE_02]
        end
      end else begin
        case (q.st)
          D_RX: begin
            if (rise && q.bitcnt < 4'h8) begin
              d.sh = {q.sh[6:0], sda_n};
              d.bitcnt = q.bitcnt + 4'h1;
            end else if (fall && q.bitcnt == 4'h8) begin
              d.bitcnt = 4'h0;
              d.sda_oe = 1'b1;
              d.st = D_ACK;
              case (q.kind)
                K_CTRL: begin
                  // silent while programming, and for other addresses
                  if (q.sh[7:1] != SLAVE_ADDR || busy) begin // [RULE_01] [RULE_18]
                    d.sda_oe = 1'b0;
                    d.st = D_IDLE;
                  end
                  d.nxt = q.sh[0] ? D_TX : D_RX; // [RULE_12]
                  d.kind = K_ADDR;
                end
                K_ADDR: begin
                  d.ptr = q.sh[ADDR_W-1:0]; // [RULE_11]
                  d.kind = K_DATA;
                  d.nxt = D_RX;
                end
                K_DATA: begin
                  // later bytes overwrite earlier ones in the same page
                  d.pbuf[q.ptr[2:0]] = q.sh;
                  d.pmask[q.ptr[2:0]] = 1'b1;
                  d.page = q.ptr[6:3];
                  d.ptr[2:0] = q.ptr[2:0] + 3'h1; // [RULE_20]
                  d.nxt = D_RX;
                end
                default: begin
                  d.st = D_IDLE;
                  d.sda_oe = 1'b0;
                end
              endcase
            end
          end
          D_ACK: begin
            if (fall) begin
              d.sda_oe = 1'b0;
              d.st = q.nxt;
              // reading: first bit goes out on this same fall
              if (q.nxt == D_TX) begin
                d.sh = {q.mem[q.ptr][6:0], 1'b1}; // [RULE_09] [RULE_12]
                d.sda_oe = ~q.mem[q.ptr][7];
                d.bitcnt = 4'h1;
                d.ptr = q.ptr + ADDR_W'(1); // [RULE_14] [RULE_22]
              end
            end
          end
          D_TX: begin
            if (fall) begin
              if (q.bitcnt < 4'h8) begin
                d.sda_oe = ~q.sh[7];
                d.sh = {q.sh[6:0], 1'b1};
                d.bitcnt = q.bitcnt + 4'h1;
              end else begin
                d.sda_oe = 1'b0;
                d.st = D_TACK;
              end
            end
          end
          D_TACK: begin
            if (rise) begin
              if (sda_n) begin
                d.st = D_IDLE; // [RULE_10]
              end else begin
                d.sh = q.mem[q.ptr]; // [RULE_13]
                d.bitcnt = 4'h0;
                d.ptr = q.ptr + ADDR_W'(1); // [RULE_14] [RULE_22]
                d.st = D_TX;
              end
            end
          end
          default: begin
            d.st = D_IDLE;
          end
        endcase
      end
    end
  end

  // state register; only power-up leaves bidirectional mode
  always_ff @(posedge link_clk or posedge reset) begin
    if (reset) begin
      q <= '0; // [RULE_19]
      q.mem <= {MEM_DEPTH{MEM_RESET}};
      q.scl_s <= 3'h7;
      q.sda_s <= 3'h7;
      q.toc_s <= 3'h0;
      q.wp_s <= 2'h3;
      q.st <= D_IDLE;
      q.nxt <= D_IDLE;
      q.kind <= K_CTRL;
    end else begin
      q <= d;
    end
  end

  // open drain: value is always low, enable does the work
  assign bus.dev_sda_o = 1'b0;
  assign bus.dev_sda_oe = q.sda_oe; // [RULE_17]
  assign bidi_mode = q.bidi;
  assign write_busy = (q.busy_cnt != '0);
  assign fuse_set = q.fuse;
endmodule // dmsea_device

// file: tb/dmsea_chk.sv
/*
  concurrent checks on the link between host and eeprom ends.
  assumes the bench feeds it the shared bus lines and device status.
*/
`timescale 1ns/1ps
module dmsea_chk #(
  parameter int WRITE_CYCLES = dmsea_pkg::WRITE_CYCLES
) (
  // clocks and reset
  input wire logic clk,
  input wire logic link_clk,
  input wire logic reset,
  // bus lines
  input wire logic host_scl_oe,
  input wire logic host_sda_oe,
  input wire logic dev_sda_oe,
  input wire logic scl,
  // device status
  input wire logic bidi_mode,
  input wire logic write_busy,
  input wire logic fuse_set
);
  logic [23:0] busy_cnt_q; // link cycles spent busy so far
  // busy length counter; cleared when idle so every write cycle is timed alone
  always_ff @(posedge link_clk or posedge reset) begin
    if (reset) begin
      busy_cnt_q <= 24'h0;
    end else begin
      busy_cnt_q <= write_busy ? busy_cnt_q + 24'h1 : 24'h0;
    end
  end
  property p_busy_quiet;
    @(posedge link_clk) disable iff (reset) write_busy |-> !dev_sda_oe;
  endproperty
  a_busy_quiet: assert property (p_busy_quiet) else $error("data driven while busy");
  // one cycle slack: the busy flag and the counter cross the same edge
  property p_busy_len;
    @(posedge link_clk) disable iff (reset) $fell(write_busy) |->
      (busy_cnt_q >= WRITE_CYCLES - 1) && (busy_cnt_q <= WRITE_CYCLES + 1);
  endproperty
  a_busy_len: assert property (p_busy_len) else $error("write cycle length off");
  property p_bidi_hold;
    @(posedge link_clk) disable iff (reset) bidi_mode |=> bidi_mode;
  endproperty
  a_bidi_hold: assert property (p_bidi_hold) else $error("left two-way mode");
  property p_txo_stay;
    @(posedge link_clk) disable iff (reset)
      !bidi_mode && scl && $past(scl) && $past(scl, 2) && $past(scl, 4) |=> !bidi_mode;
  endproperty
  a_txo_stay: assert property (p_txo_stay) else $error("mode left with clock high");
  property p_fuse_hold;
    @(posedge link_clk) disable iff (reset) fuse_set |=> fuse_set;
  endproperty
  a_fuse_hold: assert property (p_fuse_hold) else $error("fuse cleared");
  // the fuse may only move together with a stored write
  property p_fuse_store;
    @(posedge link_clk) disable iff (reset) $rose(fuse_set) |-> ##[0:2] write_busy;
  endproperty
  a_fuse_store: assert property (p_fuse_store) else $error("fuse set without store");
  property p_dev_data;
    @(posedge link_clk) disable iff (reset) bidi_mode && $changed(dev_sda_oe) |-> !scl;
  endproperty
  a_dev_data: assert property (p_dev_data) else $error("device data moved, clock high");
  property p_host_data;
    @(posedge clk) disable iff (reset) $changed(host_sda_oe) && $past(host_scl_oe) |-> host_scl_oe;
  endproperty
  a_host_data: assert property (p_host_data) else $error("host data and clock moved");
endmodule // dmsea_chk

// file: tb/dmsea_bench.sv
/*
  self-checking bench: host and device ends joined by the bus interface.
  assumes short counts: quarter bit of 8 clocks, write cycle of 2000 link clocks.
*/
`timescale 1ns/1ps
module dmsea_bench;
  import dmsea_pkg::*;
  localparam int QTR = 8; // shortest quarter the device sync allows
  localparam int WCYC = 2000; // long enough that polls see busy
  logic clk = 1'b0, link_clk = 1'b0, reset = 1'b1;
  logic cmd_valid, cmd_ready, txo_run, we_lvl, prot_lvl, rx_valid, done, done_ack;
  logic bidi_mode, write_busy, fuse_set;
  dmsea_op_e cmd_op;
  logic [6:0] cmd_addr;
  logic [7:0] cmd_wdata, cmd_count, rx_data;
  logic [7:0] rxq[$]; // bytes of the last read
  int num_errors = 0, cmp_count = 0, npoll;
  // system clock, 100 ns
  always #50 clk = ~clk;
  // link clock, 64 ns, offset so edges drift against clk
  initial begin
    #13;
    forever #32 link_clk = ~link_clk;
  end
  dmsea_bus_if dmsea_bus_if_inst ();
  dmsea_host #(.QTR_CYCLES(QTR)) dmsea_host_inst (.clk(clk), .reset(reset),
    .bus(dmsea_bus_if_inst), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_op(cmd_op),
    .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata), .cmd_count(cmd_count), .txo_run(txo_run),
    .write_enable_level(we_lvl), .protect_level(prot_lvl), .rx_valid(rx_valid),
    .rx_data(rx_data), .done(done), .done_ack(done_ack));
  dmsea_device #(.WRITE_CYCLES(WCYC)) dmsea_device_inst (.link_clk(link_clk), .reset(reset),
    .bus(dmsea_bus_if_inst), .bidi_mode(bidi_mode), .write_busy(write_busy),
    .fuse_set(fuse_set));
  dmsea_chk #(.WRITE_CYCLES(WCYC)) dmsea_chk_inst (.clk(clk), .link_clk(link_clk),
    .reset(reset), .host_scl_oe(dmsea_bus_if_inst.host_scl_oe),
    .host_sda_oe(dmsea_bus_if_inst.host_sda_oe), .dev_sda_oe(dmsea_bus_if_inst.dev_sda_oe),
    .scl(dmsea_bus_if_inst.scl), .bidi_mode(bidi_mode), .write_busy(write_busy),
    .fuse_set(fuse_set));
  // verdict and end of run
  task automatic stop_test();
    if (num_errors == 0 && cmp_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // byte and flag compares
  task automatic chk_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic chk_bit(input string what, input logic exp, input logic got);
    chk_byte(what, {7'h0, exp}, {7'h0, got});
  endtask
  // one host command; read bytes gathered in rxq, sampled after each edge
  task automatic run_cmd(input dmsea_op_e op, input logic [6:0] a, input logic [7:0] d,
      input logic [7:0] n);
    int w;
    rxq.delete();
    @(posedge clk);
    cmd_valid <= 1'b1;
    cmd_op <= op;
    cmd_addr <= a;
    cmd_wdata <= d;
    cmd_count <= n;
    @(posedge clk);
    cmd_valid <= 1'b0;
    #1 chk_bit("ready", 1'b0, cmd_ready);
    for (w = 0; w < 20000; w++) begin
      @(posedge clk);
      #1;
      if (rx_valid === 1'b1) rxq.push_back(rx_data);
      if (done === 1'b1) break;
    end
    chk_bit("done", 1'b1, done);
  endtask
  // write then poll until acked; drop_we lowers the enable during the cycle
  task automatic do_write(input logic [6:0] a, input logic [7:0] d, input logic drop_we,
      input logic [7:0] n = 8'h00);
    run_cmd(OP_WRITE, a, d, n);
    chk_bit("write ack", 1'b1, done_ack);
    if (drop_we) we_lvl <= 1'b0;
    npoll = 0;
    do begin
      run_cmd(OP_POLL, a, d, 8'h00);
      npoll++;
    end while (done_ack !== 1'b1 && npoll < 40);
    chk_bit("poll ack", 1'b1, done_ack);
  endtask
  // stream of an erased array stays high; clock line untouched keeps mode
  task automatic t_txo();
    logic hi;
    hi = 1'b1;
    @(posedge clk);
    txo_run <= 1'b1;
    repeat (400) begin
      @(posedge clk);
      hi = hi & dmsea_bus_if_inst.sda;
    end
    chk_bit("stream sda", 1'b1, hi);
    chk_bit("transmit-only", 1'b0, bidi_mode);
    txo_run <= 1'b0;
    we_lvl <= 1'b1;
  endtask
  // pin low but fuse clear: writes still land; polls see the busy cycle
  task automatic t_write_poll();
    @(posedge clk);
    prot_lvl <= 1'b0;
    do_write(7'h10, 8'ha5, 1'b0);
    chk_bit("polled busy", 1'b1, npoll > 1);
    chk_bit("two-way mode", 1'b1, bidi_mode);
    do_write(7'h11, 8'h3c, 1'b0);
  endtask
  task automatic t_reads();
    run_cmd(OP_READ_RAND, 7'h10, 8'h00, 8'h00);
    chk_byte("random read", 8'ha5, rxq[0]);
    chk_bit("read ack", 1'b1, done_ack);
    run_cmd(OP_READ_CUR, 7'h00, 8'h00, 8'h00);
    chk_byte("current read", 8'h3c, rxq[0]);
  endtask
  // last location sets the fuse; sequential read crosses the wrap
  task automatic t_fuse_seq();
    @(posedge clk);
    prot_lvl <= 1'b1;
    chk_bit("fuse clear", 1'b0, fuse_set);
    do_write(7'h7f, 8'h5a, 1'b0);
    chk_bit("fuse set", 1'b1, fuse_set);
    do_write(7'h00, 8'hc3, 1'b0);
    run_cmd(OP_READ_RAND, 7'h7e, 8'h00, 8'h02);
    chk_byte("seq 7e", 8'hff, rxq[0]);
    chk_byte("seq 7f", 8'h5a, rxq[1]);
    chk_byte("seq wrap", 8'hc3, rxq[2]);
  endtask
  // pin low, then enable low: both refused; enable dropped mid-cycle is ignored
  task automatic t_protect();
    @(posedge clk);
    prot_lvl <= 1'b0;
    do_write(7'h10, 8'h00, 1'b0);
    @(posedge clk);
    prot_lvl <= 1'b1;
    we_lvl <= 1'b0;
    do_write(7'h10, 8'h11, 1'b0);
    run_cmd(OP_READ_RAND, 7'h10, 8'h00, 8'h00);
    chk_byte("protected kept", 8'ha5, rxq[0]);
    @(posedge clk);
    we_lvl <= 1'b1;
    do_write(7'h27, 8'h40, 1'b0, 8'h01);
    run_cmd(OP_READ_RAND, 7'h20, 8'h00, 8'h07);
    chk_byte("page wrap", 8'h41, rxq[0]);
    chk_byte("page start", 8'h40, rxq[7]);
    do_write(7'h10, 8'h77, 1'b1);
    run_cmd(OP_READ_RAND, 7'h10, 8'h00, 8'h00);
    chk_byte("cycle finished", 8'h77, rxq[0]);
  endtask
  // main sequence
  initial begin
    cmd_valid = 1'b0;
    cmd_op = OP_WRITE;
    cmd_addr = 7'h00;
    cmd_wdata = 8'h00;
    cmd_count = 8'h00;
    txo_run = 1'b0;
    we_lvl = 1'b0;
    prot_lvl = 1'b1;
    repeat (16) @(posedge clk);
    reset <= 1'b0;
    t_txo();
    t_write_poll();
    t_reads();
    t_fuse_seq();
    t_protect();
    stop_test();
  end
  // watchdog, well beyond the expected run of some 30000 clocks
  initial begin
    repeat (90000) @(posedge clk);
    num_errors++;
    stop_test();
  end
endmodule // dmsea_bench
